// File: bic_conditioner.sv
`timescale 1ns/1ns
module bic_conditioner
  import bic_pkg::*;
#(
  parameter int TICK_CYCLES = BIC_TICK_CYCLES
)
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [BIC_CHANNELS-1:0] bin_in,
  output logic [BIC_CHANNELS-1:0]      cond_level,
  input  wire logic [BIC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [BIC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  typedef logic [BIC_CHANNELS-1:0][BIC_TIME_W-1:0] bic_times_t;

  typedef struct packed {
    logic [BIC_TICK_CNT_W-1:0] tick_cnt;
    logic                      tick;
    logic                      awready;
    logic                      wready;
    logic                      aw_got;
    logic                      w_got;
    logic [BIC_ADDR_W-1:0]     waddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
    logic [BIC_CHANNELS-1:0]   dgl_en;
    logic [BIC_CHANNELS-1:0]   dbn_en;
    bic_times_t                dgl_time;
    bic_times_t                dbn_time;
    logic [BIC_CHANNELS-1:0]   cnt_clr;
  } bic_state_t;

  bic_state_t st;
  bic_state_t next_st;

  logic [BIC_CHANNELS-1:0][BIC_COUNT_W-1:0] counts;

  localparam logic [BIC_TICK_CNT_W-1:0] TICK_LAST =
    BIC_TICK_CNT_W'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_bank(
    logic [7:0] a,
    logic [7:0] base
  );
    return (a >= base) && (a < base + BIC_BANK_SPAN) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] bank_index(
    logic [7:0] a,
    logic [7:0] base
  );
    logic [7:0] off;
    off = a - base;
    return off[5:2];
  endfunction

  function automatic logic [BIC_TIME_W-1:0] clamp_time(
    logic [BIC_TIME_W-1:0] v
  );
    return (v > BIC_FILT_MAX_TICKS) ? BIC_FILT_MAX_TICKS : v;
  endfunction

  function automatic logic [31:0] merge(
    logic [31:0] old,
    logic [31:0] neu,
    logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = neu[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Main next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] word;
    logic [31:0] rd;
    logic        rd_err;
    logic        wr_err;
    logic [3:0]  ch;
    word = BIC_ZERO_WORD;
    rd = BIC_ZERO_WORD;
    rd_err = 1'b0;
    wr_err = 1'b0;
    ch = '0;
    next_st = st;

    // Sampling tick
    if (st.tick_cnt >= TICK_LAST) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + BIC_TICK_CNT_W'(1);
      next_st.tick = 1'b0;
    end

    next_st.cnt_clr = '0;

    // Write address and data, either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end

    // Register write once both halves are held
    if (st.aw_got && st.w_got && !st.bvalid) begin
      if (st.waddr == BIC_REG_ENABLE) begin
        word = merge({6'h00, st.dbn_en, 6'h00, st.dgl_en},
                     st.wdata, st.wstrb);
        next_st.dgl_en =
          word[BIC_LO_FIELD +: BIC_CHANNELS];
        next_st.dbn_en =
          word[BIC_HI_FIELD +: BIC_CHANNELS];
      end else if (st.waddr == BIC_REG_CLEAR) begin
        word = merge(BIC_ZERO_WORD, st.wdata, st.wstrb);
        next_st.cnt_clr = word[BIC_CHANNELS-1:0];
      end else if (st.waddr == BIC_REG_LEVEL) begin
        wr_err = 1'b0;
      end else if (in_bank(st.waddr, BIC_REG_DGL)) begin
        ch = bank_index(st.waddr, BIC_REG_DGL);
        if (st.wstrb[0]) begin
          next_st.dgl_time[ch] =
            clamp_time(st.wdata[BIC_TIME_W-1:0]);
        end
      end else if (in_bank(st.waddr, BIC_REG_DBN)) begin
        ch = bank_index(st.waddr, BIC_REG_DBN);
        if (st.wstrb[0]) begin
          next_st.dbn_time[ch] =
            clamp_time(st.wdata[BIC_TIME_W-1:0]);
        end
      end else if (in_bank(st.waddr, BIC_REG_COUNT)) begin
        wr_err = 1'b0;
      end else begin
        wr_err = 1'b1;
      end
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_err ? BIC_RESP_SLVERR : BIC_RESP_OKAY;
    end

    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
    end

    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    // Register read
    if (s_axi_arvalid && st.arready) begin
      if (s_axi_araddr == BIC_REG_ENABLE) begin
        rd[BIC_LO_FIELD +: BIC_CHANNELS] = st.dgl_en;
        rd[BIC_HI_FIELD +: BIC_CHANNELS] = st.dbn_en;
      end else if (s_axi_araddr == BIC_REG_LEVEL) begin
        rd[BIC_LO_FIELD +: BIC_CHANNELS] = cond_level;
        rd[BIC_HI_FIELD +: BIC_CHANNELS] = bin_in;
      end else if (s_axi_araddr == BIC_REG_CLEAR) begin
        rd = BIC_ZERO_WORD;
      end else if (in_bank(s_axi_araddr, BIC_REG_DGL)) begin
        ch = bank_index(s_axi_araddr, BIC_REG_DGL);
        rd[BIC_TIME_W-1:0] = st.dgl_time[ch];
      end else if (in_bank(s_axi_araddr, BIC_REG_DBN)) begin
        ch = bank_index(s_axi_araddr, BIC_REG_DBN);
        rd[BIC_TIME_W-1:0] = st.dbn_time[ch];
      end else if (in_bank(s_axi_araddr, BIC_REG_COUNT)) begin
        ch = bank_index(s_axi_araddr, BIC_REG_COUNT);
        rd = counts[ch];
      end else begin
        rd_err = 1'b1;
      end
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = rd_err ? BIC_RESP_SLVERR : BIC_RESP_OKAY;
    end

    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    next_st.arready = !next_st.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.tick_cnt <= '0;
      st.tick     <= 1'b0;
      st.awready  <= 1'b0;
      st.wready   <= 1'b0;
      st.aw_got   <= 1'b0;
      st.w_got    <= 1'b0;
      st.waddr    <= '0;
      st.wdata    <= BIC_ZERO_WORD;
      st.wstrb    <= '0;
      st.bvalid   <= 1'b0;
      st.bresp    <= BIC_RESP_OKAY;
      st.arready  <= 1'b0;
      st.rvalid   <= 1'b0;
      st.rresp    <= BIC_RESP_OKAY;
      st.rdata    <= BIC_ZERO_WORD;
      st.dgl_en   <= BIC_EN_RESET;
      st.dbn_en   <= BIC_EN_RESET;
      st.dgl_time <= {BIC_CHANNELS{BIC_TIME_RESET}};
      st.dbn_time <= {BIC_CHANNELS{BIC_TIME_RESET}};
      st.cnt_clr  <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel filters and counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < BIC_CHANNELS; i++) begin : g_chan
    bic_channel u_channel (
      .clock    (clock),
      .rst_n    (rst_n),
      .tick     (st.tick),
      .din      (bin_in[i]),
      .dgl_en   (st.dgl_en[i]),
      .dbn_en   (st.dbn_en[i]),
      .dgl_time (st.dgl_time[i]),
      .dbn_time (st.dbn_time[i]),
      .level    (cond_level[i])
    );

    bic_pulse_counter u_counter (
      .clock (clock),
      .rst_n (rst_n),
      .level (cond_level[i]),
      .clear (st.cnt_clr[i]),
      .count (counts[i])
    );
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = st.rdata;

endmodule

// File: bic_pkg.sv
package bic_pkg;

  // ----------------------------------------------------------------
  // Channel structure
  // ----------------------------------------------------------------
  localparam int BIC_CHANNELS = 10;
  localparam int BIC_TIME_W   = 8;
  localparam int BIC_COUNT_W  = 32;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BIC_CLK_NS        = 20;
  localparam int BIC_TICK_NS       = 100_000;
  localparam int BIC_TICK_CYCLES   = BIC_TICK_NS / BIC_CLK_NS;
  localparam int BIC_TICK_US       = 100;
  localparam int BIC_FILT_MAX_US   = 25_000;
  localparam logic [BIC_TIME_W-1:0] BIC_FILT_MAX_TICKS =
    BIC_TIME_W'(BIC_FILT_MAX_US / BIC_TICK_US);
  localparam int BIC_TICK_CNT_W    = 16;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int          BIC_ADDR_W    = 8;
  localparam logic [7:0] BIC_REG_ENABLE = 8'h00;
  localparam logic [7:0] BIC_REG_LEVEL  = 8'h04;
  localparam logic [7:0] BIC_REG_CLEAR  = 8'h08;
  localparam logic [7:0] BIC_REG_DGL    = 8'h40;
  localparam logic [7:0] BIC_REG_DBN    = 8'h80;
  localparam logic [7:0] BIC_REG_COUNT  = 8'hC0;
  localparam logic [7:0] BIC_BANK_SPAN  = 8'(BIC_CHANNELS * 4);

  // Field positions in the enable and level registers
  localparam int BIC_LO_FIELD = 0;
  localparam int BIC_HI_FIELD = 16;

  // ----------------------------------------------------------------
  // Reset values and responses
  // ----------------------------------------------------------------
  localparam logic [BIC_CHANNELS-1:0] BIC_EN_RESET   = 10'h000;
  localparam logic [BIC_TIME_W-1:0]   BIC_TIME_RESET = 8'h00;
  localparam logic [1:0]  BIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  BIC_RESP_SLVERR = 2'h2;
  localparam logic [31:0] BIC_ZERO_WORD   = 32'h0000_0000;

endpackage

// File: bic_pulse_counter.sv
`timescale 1ns/1ns
module bic_pulse_counter
  import bic_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   level,
  input  wire logic                   clear,
  output logic [BIC_COUNT_W-1:0]      count
);

  typedef struct packed {
    logic                   prev;
    logic [BIC_COUNT_W-1:0] count;
  } bic_cnt_state_t;

  bic_cnt_state_t st;
  bic_cnt_state_t next_st;

  // ----------------------------------------------------------------
  // Rising edge count, a rise in the clear cycle loads one
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    rise = 1'b0;
    next_st = st;
    rise = level & ~st.prev;
    next_st.prev = level;
    if (clear) begin
      next_st.count = rise ? BIC_COUNT_W'(1) : '0;
    end else if (rise) begin
      next_st.count = st.count + BIC_COUNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

endmodule

// File: bic_channel.sv
`timescale 1ns/1ns
module bic_channel
  import bic_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  tick,
  input  wire logic                  din,
  input  wire logic                  dgl_en,
  input  wire logic                  dbn_en,
  input  wire logic [BIC_TIME_W-1:0] dgl_time,
  input  wire logic [BIC_TIME_W-1:0] dbn_time,
  output logic                       level
);

  typedef struct packed {
    logic                  sample;
    logic [BIC_TIME_W-1:0] run;
    logic                  dgl_out;
    logic [BIC_TIME_W-1:0] hold;
    logic                  level;
  } bic_chan_state_t;

  bic_chan_state_t st;
  bic_chan_state_t next_st;

  // ----------------------------------------------------------------
  // Deglitch then debounce, evaluated once per tick
  // ----------------------------------------------------------------
  always_comb begin
    logic dg;
    logic [BIC_TIME_W-1:0] run;
    dg = 1'b0;
    run = '0;
    next_st = st;
    if (tick) begin
      next_st.sample = din;
      if (din != st.sample) begin
        run = BIC_TIME_W'(1);
      end else if (st.run != '1) begin
        run = st.run + BIC_TIME_W'(1);
      end else begin
        run = st.run;
      end
      next_st.run = run;
      if (dgl_en && dgl_time != '0) begin
        dg = (run >= dgl_time) ? din : st.dgl_out;
      end else begin
        dg = din;
      end
      next_st.dgl_out = dg;
      if (dbn_en && dbn_time != '0) begin
        if (st.hold > BIC_TIME_W'(1)) begin
          next_st.hold = st.hold - BIC_TIME_W'(1);
        end else if (dg != st.level) begin
          next_st.level = dg;
          next_st.hold = dbn_time;
        end else begin
          next_st.hold = '0;
        end
      end else begin
        next_st.level = dg;
        next_st.hold = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

// File: bic_conditioner_monitor.sv
`timescale 1ns/1ns
module bic_conditioner_monitor
  import bic_pkg::*;
#(
  parameter int TICK_CYCLES = BIC_TICK_CYCLES
)
(
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic [BIC_CHANNELS-1:0] cond_level,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [BIC_ADDR_W-1:0]   s_axi_araddr,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Spacing of output changes
  // ----------------------------------------------------------------
  logic [BIC_CHANNELS-1:0] prev_level;
  logic [15:0]             gap;
  logic                    seen;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_level <= '0;
      gap        <= 16'h0000;
      seen       <= 1'b0;
    end else begin
      prev_level <= cond_level;
      gap        <= (cond_level != prev_level) ? 16'h0001 : gap + 16'h0001;
      seen       <= seen | (cond_level != prev_level);
    end
  end

  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after address");
  a_write_answer: assert property (s_wr_take |=>
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response not on time");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h30 |=> s_axi_rresp == BIC_RESP_SLVERR &&
    s_axi_rdata == BIC_ZERO_WORD)
    else $error("unmapped read not refused");
  a_level_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == BIC_REG_LEVEL |=>
    s_axi_rdata[BIC_CHANNELS-1:0] == $past(cond_level))
    else $error("level register differs from outputs");
  a_tick_spacing: assert property (seen && cond_level != prev_level |->
    (gap % TICK_CYCLES) == 0)
    else $error("output changed off the sampling tick");
endmodule

// File: bic_comparator_model.sv
`timescale 1ns/1ns
module bic_comparator_model
  import bic_pkg::*;
#(
  parameter int MIN_PHASE = 16
)
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [BIC_CHANNELS-1:0] target,
  output logic [BIC_CHANNELS-1:0]      bin_in
);
  // ----------------------------------------------------------------
  // Comparator outputs, each phase held a minimum time
  // ----------------------------------------------------------------
  int held;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bin_in <= '0;
      held   <= 0;
    end else if (target != bin_in && held >= MIN_PHASE - 1) begin
      bin_in <= target;
      held   <= 0;
    end else begin
      held <= held + 1;
    end
  end
endmodule

// File: bic_conditioner_tb_top.sv
`timescale 1ns/1ns
module bic_conditioner_tb_top
  import bic_pkg::*;
;
  localparam int TC = 10;
  logic                    clock = 1'b0;
  logic                    rst_n = 1'b0;
  logic [BIC_CHANNELS-1:0] target = '0;
  logic [BIC_CHANNELS-1:0] bin_in;
  logic [BIC_CHANNELS-1:0] cond_level;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] d;
  logic [1:0]  r;

  bic_comparator_model u_cmp (.clock(clock), .rst_n(rst_n), .target(target),
    .bin_in(bin_in));
  bic_conditioner #(.TICK_CYCLES(TC)) DUT (.clock(clock), .rst_n(rst_n),
    .bin_in(bin_in), .cond_level(cond_level), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ----------------------------------------------------------------
  // Clock, timeout, verdict
  // ----------------------------------------------------------------
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_lvl(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (tb !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
    logic ta, tr;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      v  = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (tr !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    axi_read(a, d, r);
    chk_word(d, e);
    chk_resp(r, er);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] v,
                        input logic [1:0] er);
    axi_write(a, v, r);
    chk_resp(r, er);
  endtask
  task automatic set_in(input int i, input logic v);
    @(posedge clock);
    target[i] <= v;
  endtask
  task automatic look(input int n, input logic [9:0] e);
    repeat (n) @(posedge clock);
    #1;
    chk_lvl(cond_level, e);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(BIC_REG_ENABLE, 32'h0000_0000, BIC_RESP_OKAY);
    for (int i = 0; i < BIC_CHANNELS; i++) begin
      rd_chk(BIC_REG_DGL + 8'(4 * i), 32'h0000_0000, BIC_RESP_OKAY);
      rd_chk(BIC_REG_DBN + 8'(4 * i), 32'h0000_0000, BIC_RESP_OKAY);
    end
    rd_chk(8'h30, 32'h0000_0000, BIC_RESP_SLVERR);
    rd_chk(8'h02, 32'h0000_0000, BIC_RESP_SLVERR);
    wr_chk(8'h30, 32'h0000_0001, BIC_RESP_SLVERR);
    wr_chk(8'h54, 32'h0000_00FF, BIC_RESP_OKAY);
    rd_chk(8'h54, 32'h0000_00FA, BIC_RESP_OKAY);
    wr_chk(8'h54, 32'h0000_0019, BIC_RESP_OKAY);
    rd_chk(8'h54, 32'h0000_0019, BIC_RESP_OKAY);
    wr_chk(8'h44, 32'h0000_0003, BIC_RESP_OKAY);
    wr_chk(8'h4C, 32'h0000_0002, BIC_RESP_OKAY);
    wr_chk(8'h88, 32'h0000_0004, BIC_RESP_OKAY);
    wr_chk(8'h8C, 32'h0000_0003, BIC_RESP_OKAY);
    wr_chk(BIC_REG_ENABLE, 32'h000C_000A, BIC_RESP_OKAY);
    rd_chk(BIC_REG_ENABLE, 32'h000C_000A, BIC_RESP_OKAY);
    set_in(0, 1'b1);
    look(13, 10'h001);
    set_in(1, 1'b1);
    repeat (15) @(posedge clock);
    set_in(1, 1'b0);
    look(40, 10'h001);
    set_in(1, 1'b1);
    look(15, 10'h001);
    look(19, 10'h003);
    set_in(2, 1'b1);
    look(12, 10'h007);
    set_in(2, 1'b0);
    look(11, 10'h007);
    look(30, 10'h003);
    set_in(2, 1'b1);
    look(15, 10'h003);
    look(30, 10'h007);
    set_in(3, 1'b1);
    look(8, 10'h007);
    look(16, 10'h00F);
    rd_chk(BIC_REG_LEVEL, 32'h000F_000F, BIC_RESP_OKAY);
    rd_chk(BIC_REG_COUNT, 32'h0000_0001, BIC_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      set_in(4, 1'b1);
      repeat (20) @(posedge clock);
      set_in(4, 1'b0);
      repeat (20) @(posedge clock);
    end
    rd_chk(8'hD0, 32'h0000_0003, BIC_RESP_OKAY);
    wr_chk(BIC_REG_CLEAR, 32'h0000_0010, BIC_RESP_OKAY);
    rd_chk(8'hD0, 32'h0000_0000, BIC_RESP_OKAY);
    rd_chk(BIC_REG_CLEAR, 32'h0000_0000, BIC_RESP_OKAY);
    wr_chk(BIC_REG_LEVEL, 32'h0000_0000, BIC_RESP_OKAY);
    rd_chk(BIC_REG_LEVEL, 32'h000F_000F, BIC_RESP_OKAY);
    end_sim();
  end
endmodule

bind bic_conditioner bic_conditioner_monitor #(.TICK_CYCLES(TICK_CYCLES))
  u_mon (.clock(clock), .rst_n(rst_n), .cond_level(cond_level),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
